// ==== tdf_host.sv ====
// host model on the far side of the two-wire link: clocks only inside frames
// assumes: wire_in is the resolved data pin level, dev_oe_in the device enable
module tdf_host (
   output logic      link_clk_out,
   output logic      host_do_out,
   output logic      host_oe_out,
   input  wire logic wire_in,
   input  wire logic dev_oe_in
);
   timeunit 1ns;
   timeprecision 100ps;
   import tdf_pkg::*;
   int   oe_cnt;  // edges seen with the device driving
   int   tmo;     // ready waits that ran out
   logic smp;     // pin level just before an edge
   logic soe;     // device enable just before an edge
   initial begin
      link_clk_out = 1'b0;
      host_do_out = 1'b0;
      host_oe_out = 1'b0;
      oe_cnt = 0;
      tmo = 0;
   end
   // one 6 ns period; a released line toggles so a stale level never reads as valid
   task automatic pulse(input logic drive, input logic bit_v);
      host_oe_out = drive;
      host_do_out = drive ? bit_v : ~host_do_out;
      #3;
      smp = wire_in;
      soe = dev_oe_in;
      if (dev_oe_in === 1'b1) oe_cnt++;
      link_clk_out = 1'b1;
      #3;
      link_clk_out = 1'b0;
   endtask
   // bits leave lsb first
   task automatic send(input logic [7:0] v, input int n);
      for (int i = 0; i < n; i++) pulse(1'b1, v[i]);
   endtask
   task automatic recv(output logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         pulse(1'b0, 1'b0);
         v[i] = smp;
      end
   endtask
   // keep clocking until the device shows its ready bit, bounded
   task automatic wait_rdy();
      int k;
      k = 0;
      do begin
         pulse(1'b0, 1'b0);
         k++;
      end while (!(smp === 1'b1 && soe === 1'b1) && k < 500);
      if (k >= 500) tmo++;
   endtask
   task automatic sel_wr(input logic [7:0] a);
      send({6'h00, INS_ADDR_WR}, 2);
      send(a, 8);
   endtask
   task automatic sel_rd(output logic [7:0] v);
      send({6'h00, INS_ADDR_RD}, 2);
      recv(v);
   endtask
   task automatic dat_wr(input logic [7:0] d);
      send({6'h00, INS_DATA_WR}, 2);
      send(d, 8);
      wait_rdy();
   endtask
   task automatic dat_rd(output logic [7:0] v);
      send({6'h00, INS_DATA_RD}, 2);
      wait_rdy();
      recv(v);
   endtask
endmodule // tdf_host

// ==== tdf_pkg.sv ====
// constants and types for the two-wire debug register set
// assumes: included before tdf_top.sv
package tdf_pkg;
   // link register addresses
   localparam logic [7:0] ADDR_PART   = 8'h00;
   localparam logic [7:0] ADDR_REV    = 8'h01;
   localparam logic [7:0] ADDR_UNLOCK = 8'h02;
   localparam logic [7:0] ADDR_DATA   = 8'hB4;
   // reset values, and the read value of unmapped addresses
   localparam logic [7:0] SEL_RESET    = 8'h00;
   localparam logic [7:0] UNLOCK_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET   = 8'h00;
   localparam logic [7:0] UNMAPPED_VAL = 8'h00;
   // unlock codes, in order
   localparam logic [7:0] UNLOCK_FIRST  = 8'h02;
   localparam logic [7:0] UNLOCK_SECOND = 8'h01;
   // flash command codes
   localparam logic [7:0] CMD_BLOCK_READ  = 8'h06;
   localparam logic [7:0] CMD_BLOCK_WRITE = 8'h07;
   localparam logic [7:0] CMD_PAGE_ERASE  = 8'h08;
   localparam logic [7:0] CMD_DEV_ERASE   = 8'h03;
   // link instruction codes, first bit on the wire is bit 0
   localparam logic [1:0] INS_DATA_RD = 2'b00;
   localparam logic [1:0] INS_DATA_WR = 2'b01;
   localparam logic [1:0] INS_ADDR_WR = 2'b10;
   localparam logic [1:0] INS_ADDR_RD = 2'b11;
   // bit counts on the link
   localparam logic [2:0] INS_LAST  = 3'h1;
   localparam logic [2:0] BYTE_LAST = 3'h7;
   // flash word fifo shape
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_WIDTH = 9;
   // unlock sequence states
   typedef enum logic [1:0] {
      UNL_IDLE  = 2'b00,
      UNL_FIRST = 2'b01,
      UNL_ON    = 2'b10
   } tdf_unlock_e;
   // link framing states
   typedef enum logic [1:0] {
      LNK_INS   = 2'b00,
      LNK_WDATA = 2'b01,
      LNK_WAIT  = 2'b10,
      LNK_RDATA = 2'b11
   } tdf_link_e;
endpackage : tdf_pkg

// ==== tdf_top.sv ====
// two-wire debug register set: link framing, crossing, registers, flash fifo
// assumes: link clock and data are host driven; halted_in is on ref_clk_in

// flash word fifo with a registered head stage
module tdf_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];   // storage array
   logic [AW-1:0]    wp_q, wp_d;      // write pointer
   logic [AW-1:0]    rp_q, rp_d;      // read pointer
   logic [AW:0]      cnt_q, cnt_d;    // words held in the array
   logic             ov_q, ov_d;      // head stage holds a word
   logic [WIDTH-1:0] od_q, od_d;      // head stage data
   logic             push, pop;
   // next state: head refills whenever it empties or is taken
   always_comb begin
      in_ready_out = (cnt_q != (AW+1)'(DEPTH));
      push = in_valid_in && in_ready_out;
      pop  = (cnt_q != '0) && (!ov_q || out_ready_in);
      wp_d = push ? wp_q + 1'b1 : wp_q;
      rp_d = pop ? rp_q + 1'b1 : rp_q;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      ov_d = pop ? 1'b1 : (out_ready_in ? 1'b0 : ov_q);
      od_d = pop ? mem_q[rp_q] : od_q;
   end
   // registers; array has no reset, pointers guard it
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         ov_q <= 1'b0;
         od_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
         ov_q <= ov_d;
         od_q <= od_d;
      end
   end
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_q[wp_q] <= in_data_in;
      end
   end
   assign out_valid_out = ov_q;
   assign out_data_out  = od_q;
endmodule : tdf_fifo

module tdf_top #(
   parameter logic [7:0] PART_ID  = 8'h5A,  // arbitrary value
   parameter logic [7:0] REVISION = 8'h01   // arbitrary value, set per silicon
) (
   input  wire logic       ref_clk_in,
   input  wire logic       rst_in,
   input  wire logic       halted_in,
   input  wire logic       link_clock_pin_in,
   input  wire logic       link_data_pin_in,
   output logic            link_data_pin_out,
   output logic            link_data_pin_oe_out,
   output logic            core_stall_out,
   output logic            programming_enabled_out,
   output logic            flash_word_valid_out,
   input  wire logic       flash_word_ready_in,
   output logic [7:0]      flash_word_out,
   output logic            flash_word_known_out,
   input  wire logic       flash_rd_valid_in,
   input  wire logic [7:0] flash_rd_data_in
);
   import tdf_pkg::*;

   // true for a recognised flash command code
   function automatic logic is_known_cmd(input logic [7:0] b);
      return (b == CMD_BLOCK_READ) || (b == CMD_BLOCK_WRITE) ||
             (b == CMD_PAGE_ERASE) || (b == CMD_DEV_ERASE);
   endfunction

   // link domain state
   tdf_link_e  lst_q, lst_d;          // framing state
   logic [2:0] bit_q, bit_d;          // bit counter within a field
   logic [7:0] sh_q, sh_d;            // shift register
   logic [1:0] ins_q, ins_d;          // current instruction
   logic [7:0] sel_q, sel_d;          // link_register_select
   logic [7:0] wdat_q, wdat_d;        // write byte held for the core
   logic       rtg_q, rtg_d;          // request toggle to core
   logic       ack1_q, ack2_q;        // ack toggle synchroniser
   logic       ackr_q, ackr_d;        // last ack seen
   logic       hl1_q, hl2_q;          // halt synchroniser
   logic       do_q, do_d;            // data pin drive value
   logic       oe_q, oe_d;            // data pin drive enable
   logic       ack_new;
   // core domain state
   logic       rq1_q, rq2_q, rq3_q;   // request synchroniser plus edge
   logic       busy_q, busy_d;        // request being served
   tdf_unlock_e unl_q, unl_d;         // unlock sequence
   logic [7:0] ctl_q, ctl_d;          // programming_unlock_control
   logic [7:0] dat_q, dat_d;          // programming_data_port
   logic [7:0] rd_q, rd_d;            // answer byte for the link
   logic       atg_q, atg_d;          // ack toggle to link
   logic       prg_q, prg_d;          // programming enabled
   logic       stl_q, stl_d;          // stall output
   logic       wr_now, push_v, push_r, is_wr;

   // link framing: instruction, optional byte, wait on data instructions only, optional read byte
   always_comb begin
      lst_d = lst_q;
      bit_d = bit_q + 1'b1;
      sh_d = {link_data_pin_in, sh_q[7:1]};
      ins_d = ins_q;
      sel_d = sel_q;
      wdat_d = wdat_q;
      rtg_d = rtg_q;
      ackr_d = ackr_q;
      do_d = 1'b0;
      oe_d = 1'b0;
      ack_new = (ack2_q != ackr_q);
      if (!hl2_q) begin                             // pins belong to user
         lst_d = LNK_INS;
         bit_d = '0;
      end else begin
         case (lst_q)
            LNK_INS: begin
               if (bit_q == INS_LAST) begin
                  ins_d = {link_data_pin_in, sh_q[7]};
                  bit_d = '0;
                  if (ins_d == INS_DATA_RD) begin
                     rtg_d = ~rtg_q;                // ask core for the byte
                     lst_d = LNK_WAIT;
                  end else if (ins_d == INS_ADDR_RD) begin
                     oe_d = 1'b1;                   // bit 0 leaves now, host samples next edge
                     do_d = sel_q[0];
                     sh_d = {1'b0, sel_q[7:1]};
                     lst_d = LNK_RDATA;
                  end else begin
                     lst_d = LNK_WDATA;
                  end
               end
            end
            LNK_WDATA: begin
               if (bit_q == BYTE_LAST) begin
                  bit_d = '0;
                  if (ins_q == INS_ADDR_WR) begin
                     sel_d = sh_d;                  // select update
                     lst_d = LNK_INS;
                  end else begin
                     wdat_d = sh_d;
                     rtg_d = ~rtg_q;
                     lst_d = LNK_WAIT;
                  end
               end
            end
            LNK_WAIT: begin
               oe_d = 1'b1;                         // 0 while busy, 1 when done
               bit_d = '0;
               if (do_q) begin                      // host has just sampled the ready bit
                  if (ins_q == INS_DATA_RD) begin
                     do_d = sh_q[0];                // read byte bit 0
                     sh_d = {1'b0, sh_q[7:1]};
                     lst_d = LNK_RDATA;
                  end else begin
                     oe_d = 1'b0;                   // write done, release the pin
                     lst_d = LNK_INS;
                  end
               end else if (ack_new) begin
                  ackr_d = ack2_q;
                  do_d = 1'b1;
                  sh_d = rd_q;                      // stable: core holds it
               end
            end
            default: begin                          // bits 1..7, last edge only releases
               oe_d = 1'b1;
               do_d = sh_q[0];
               sh_d = {1'b0, sh_q[7:1]};
               if (bit_q == BYTE_LAST) begin
                  oe_d = 1'b0;
                  do_d = 1'b0;
                  lst_d = LNK_INS;
                  bit_d = '0;
               end
            end
         endcase
      end
   end
   // every driven bit is launched one edge before the host samples it,
   // so the sampling edge still belongs to the field and never to the next frame
   always_ff @(posedge link_clock_pin_in or posedge rst_in) begin
      if (rst_in) begin
         lst_q <= LNK_INS;
         bit_q <= '0;
         sh_q <= '0;
         ins_q <= INS_DATA_RD;
         sel_q <= SEL_RESET;
         wdat_q <= '0;
         rtg_q <= 1'b0;
         ack1_q <= 1'b0;
         ack2_q <= 1'b0;
         ackr_q <= 1'b0;
         hl1_q <= 1'b0;
         hl2_q <= 1'b0;
         do_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         lst_q <= lst_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         ins_q <= ins_d;
         sel_q <= sel_d;
         wdat_q <= wdat_d;
         rtg_q <= rtg_d;
         ack1_q <= atg_q;
         ack2_q <= ack1_q;
         ackr_q <= ackr_d;
         hl1_q <= halted_in;
         hl2_q <= hl1_q;
         do_q <= do_d;
         oe_q <= oe_d;
      end
   end

   // core side: serve one request, answer by toggling the ack
   always_comb begin
      busy_d = busy_q | (rq2_q ^ rq3_q);
      unl_d = unl_q;
      ctl_d = ctl_q;
      dat_d = flash_rd_valid_in ? flash_rd_data_in : dat_q;
      rd_d = rd_q;
      atg_d = atg_q;
      is_wr = (ins_q == INS_DATA_WR);
      wr_now = busy_q && is_wr;
      push_v = wr_now && (sel_q == ADDR_DATA) && prg_q;
      if (busy_q) begin
         if (sel_q == ADDR_PART) begin
            rd_d = PART_ID;                        // writes ignored
         end else if (sel_q == ADDR_REV) begin
            rd_d = REVISION;                       // writes ignored
         end else if (sel_q == ADDR_UNLOCK) begin
            rd_d = ctl_q;
         end else if (sel_q == ADDR_DATA) begin
            rd_d = dat_q;                          // flash traffic
         end else begin
            rd_d = UNMAPPED_VAL;
         end
         if (wr_now && sel_q == ADDR_UNLOCK) begin
            ctl_d = wdat_q;
            rd_d = wdat_q;
            if (unl_q != UNL_ON) begin             // two-step unlock
               if (unl_q == UNL_FIRST && wdat_q == UNLOCK_SECOND) begin
                  unl_d = UNL_ON;
               end else if (wdat_q == UNLOCK_FIRST) begin
                  unl_d = UNL_FIRST;
               end else begin
                  unl_d = UNL_IDLE;                // broken order
               end
            end
         end
         if (wr_now && sel_q == ADDR_DATA) begin
            dat_d = wdat_q;                        // flash byte
            rd_d = wdat_q;
         end
         if (!push_v || push_r) begin              // full fifo stalls the ack
            busy_d = 1'b0;
            atg_d = ~atg_q;
         end
      end
      prg_d = (unl_d == UNL_ON);                   // sticky until reset
      stl_d = halted_in | prg_d;                   // halt stalls all
   end
   // core registers; control and data clear on reset
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rq1_q <= 1'b0;
         rq2_q <= 1'b0;
         rq3_q <= 1'b0;
         busy_q <= 1'b0;
         unl_q <= UNL_IDLE;
         ctl_q <= UNLOCK_RESET;
         dat_q <= DATA_RESET;
         rd_q <= '0;
         atg_q <= 1'b0;
         prg_q <= 1'b0;
         stl_q <= 1'b0;
      end else begin
         rq1_q <= rtg_q;
         rq2_q <= rq1_q;
         rq3_q <= rq2_q;
         busy_q <= busy_d;
         unl_q <= unl_d;
         ctl_q <= ctl_d;
         dat_q <= dat_d;
         rd_q <= rd_d;
         atg_q <= atg_d;
         prg_q <= prg_d;
         stl_q <= stl_d;
      end
   end

   // each programming byte is tagged with its command recognition
   tdf_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_in        (ref_clk_in),
      .rst_in        (rst_in),
      .in_valid_in   (push_v),
      .in_ready_out  (push_r),
      .in_data_in    ({is_known_cmd(wdat_q), wdat_q}),
      .out_valid_out (flash_word_valid_out),
      .out_ready_in  (flash_word_ready_in),
      .out_data_out  ({flash_word_known_out, flash_word_out})
   );

   assign link_data_pin_out       = do_q;
   assign link_data_pin_oe_out    = oe_q;
   assign core_stall_out          = stl_q;
   assign programming_enabled_out = prg_q;

   // checks
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   sequence unl_first_s;
      busy_q && is_wr && sel_q == ADDR_UNLOCK && wdat_q == UNLOCK_FIRST && unl_q == UNL_IDLE;
   endsequence
   sequence unl_second_s;
      busy_q && is_wr && sel_q == ADDR_UNLOCK && wdat_q == UNLOCK_SECOND && unl_q == UNL_FIRST;
   endsequence
   unlock_order_a: assert property ($rose(prg_q) |-> $past(unl_q) == UNL_FIRST)
      else $error("programming enabled without first code");
   unlock_seq_a: assert property (unl_first_s ##[1:1000] unl_second_s |=> prg_q)
      else $error("two-step unlock did not enable");
   prog_sticky_a: assert property (prg_q |=> prg_q && stl_q)
      else $error("programming mode left without reset");
   halt_stall_a: assert property (halted_in |=> core_stall_out)
      else $error("halt did not stall");
   bad_seq_a: assert property (busy_q && is_wr && sel_q == ADDR_UNLOCK && unl_q == UNL_FIRST
      && wdat_q != UNLOCK_SECOND && wdat_q != UNLOCK_FIRST |=> unl_q == UNL_IDLE)
      else $error("bad unlock sequence kept progress");
   part_id_a: assert property (busy_q && sel_q == ADDR_PART |=> rd_q == PART_ID)
      else $error("part code wrong");
   rev_id_a: assert property (busy_q && sel_q == ADDR_REV |=> rd_q == REVISION)
      else $error("revision wrong");
   data_push_a: assert property (busy_q && is_wr && sel_q == ADDR_DATA && prg_q && push_r
      |=> dat_q == $past(wdat_q) && !busy_q)
      else $error("data byte not taken");
   known_cmd_a: assert property (flash_word_valid_out && (flash_word_out == CMD_BLOCK_WRITE
      || flash_word_out == CMD_DEV_ERASE) |-> flash_word_known_out)
      else $error("known command not flagged");
   pin_release_a: assert property (@(posedge link_clock_pin_in) disable iff (rst_in)
      !hl2_q |=> !link_data_pin_oe_out)
      else $error("link drove pin while running");
endmodule : tdf_top

// ==== tdf_top_tb_top.sv ====
// self-checking bench: host model on the link, register model with a queue for flash words
// assumes: tdf_pkg, tdf_top and tdf_host compiled before
module tdf_top_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import tdf_pkg::*;
   localparam logic [7:0] PART_V = 8'h3C;  // arbitrary value
   localparam logic [7:0] REV_V  = 8'h02;  // arbitrary value
   logic       ref_clk_in, rst_in, halted_in, flash_word_ready_in, flash_rd_valid_in, drain;
   logic [7:0] flash_rd_data_in, flash_word_out, rv, d, x;
   logic       lclk, hdo, hoe, ddo, doe, wire_lvl, stall, prog, fvalid, fknown;
   logic [8:0] exp_w;
   logic [8:0] exp_q[$];  // expected flash words, known flag on top
   logic [7:0] m_sel, m_unl, m_dat;  // register model
   logic       m_prog;
   int         m_step, mismatches, num_checks, pending;
   logic [7:0] codes[4] = '{8'h06, 8'h07, 8'h08, 8'h03};
   // no pull on the data pin: the host model toggles it when nobody drives
   assign wire_lvl = doe ? ddo : hdo;
   tdf_top #(.PART_ID(PART_V), .REVISION(REV_V)) uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .halted_in(halted_in), .link_clock_pin_in(lclk), .link_data_pin_in(wire_lvl),
      .link_data_pin_out(ddo), .link_data_pin_oe_out(doe), .core_stall_out(stall),
      .programming_enabled_out(prog), .flash_word_valid_out(fvalid),
      .flash_word_ready_in(flash_word_ready_in), .flash_word_out(flash_word_out),
      .flash_word_known_out(fknown), .flash_rd_valid_in(flash_rd_valid_in),
      .flash_rd_data_in(flash_rd_data_in));
   tdf_host h (.link_clk_out(lclk), .host_do_out(hdo), .host_oe_out(hoe), .wire_in(wire_lvl),
      .dev_oe_in(doe));
   // 100 MHz core clock
   initial begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask
   // model of a data write; 02 restarts the unlock, 01 right after 02 completes it, anything else drops it
   task automatic m_wr(input logic [7:0] v);
      if (m_sel == 8'h02) begin
         m_unl = v;
         if (!m_prog) begin
            m_prog = (m_step == 1 && v == 8'h01);
            m_step = (v == 8'h02) ? 1 : 0;
         end
      end else if (m_sel == 8'hB4) begin
         m_dat = v;
         if (m_prog) exp_q.push_back({v inside {8'h06, 8'h07, 8'h08, 8'h03}, v});
      end
   endtask
   function automatic logic [7:0] m_rd();
      case (m_sel)
         8'h00: return PART_V;
         8'h01: return REV_V;
         8'h02: return m_unl;
         8'hB4: return m_dat;
         default: return 8'h00;
      endcase
   endfunction
   task automatic m_clr();
      m_sel = 8'h00;
      m_unl = 8'h00;
      m_dat = 8'h00;
      m_prog = 1'b0;
      m_step = 0;
   endtask
   // expectation goes in first: the consumer may take the word before the frame ends
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      h.sel_wr(a);
      m_sel = a;
      m_wr(v);
      h.dat_wr(v);
   endtask
   task automatic rd(input logic [7:0] a);
      h.sel_wr(a);
      m_sel = a;
      h.dat_rd(rv);
      chk8(rv, m_rd());
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // consumer with random stalls, checks every word it takes
   always @(negedge ref_clk_in) flash_word_ready_in <= drain & 1'($urandom);
   always @(posedge ref_clk_in) begin
      if (fvalid === 1'b1 && flash_word_ready_in === 1'b1) begin
         if (exp_q.size() == 0) chk1(1'b1, 1'b0);
         else begin
            exp_w = exp_q.pop_front();
            chk8(flash_word_out, exp_w[7:0]);
            chk1(fknown, exp_w[8]);
         end
      end
   end
   // watchdog, far beyond the expected run
   initial begin
      #400000;
      mismatches++;
      $display("wrong value at %0t: watchdog expired", $time);
      end_sim();
   end
   initial begin
      rst_in = 1'b1;
      halted_in = 1'b0;
      drain = 1'b0;
      flash_word_ready_in = 1'b0;
      flash_rd_valid_in = 1'b0;
      flash_rd_data_in = 8'h00;
      mismatches = 0;
      num_checks = 0;
      pending = 0;
      m_clr();
      void'($urandom(73));
      repeat (4) @(negedge ref_clk_in);
      rst_in = 1'b0;
      @(negedge ref_clk_in);
      chk1(prog, 1'b0);
      chk1(stall, 1'b0);
      h.sel_rd(rv);
      chk8(8'(h.oe_cnt), 8'h00);
      @(negedge ref_clk_in);
      halted_in = 1'b1;
      @(negedge ref_clk_in);
      chk1(stall, 1'b1);
      h.send(8'h00, 2);
      for (int i = 0; i < 2; i++) begin
         rd(8'(i));
         wr(8'(i), 8'($urandom));
         rd(8'(i));
      end
      x = {2'b11, 6'($urandom)};
      h.sel_wr(x);
      h.sel_rd(rv);
      chk8(rv, x);
      rd(x);
      wr(8'hB4, 8'h07);
      repeat (20) @(negedge ref_clk_in);
      chk1(fvalid, 1'b0);
      wr(8'h02, 8'h02);
      wr(8'h02, 8'h55);
      wr(8'h02, 8'h01);
      rd(8'h02);
      repeat (2) @(negedge ref_clk_in);
      chk1(prog, m_prog);
      wr(8'h02, 8'h02);
      wr(8'h02, 8'h02);
      wr(8'h02, 8'h01);
      repeat (2) @(negedge ref_clk_in);
      chk1(prog, 1'b1);
      wr(8'h02, 8'h00);
      @(negedge ref_clk_in);
      halted_in = 1'b0;
      repeat (3) @(negedge ref_clk_in);
      chk1(prog, 1'b1);
      chk1(stall, 1'b1);
      // no link edges ran while halt was low, so the link side never left halt
      halted_in = 1'b1;
      @(negedge ref_clk_in);
      h.sel_wr(8'hB4);
      m_sel = 8'hB4;
      for (int i = 0; i < 17; i++) begin
         d = (i < 4) ? codes[i] : 8'($urandom);
         m_wr(d);
         h.dat_wr(d);
      end
      chk1(fvalid, 1'b1);
      fork
         begin
            pending = 1;
            m_wr(8'hA5);
            h.dat_wr(8'hA5);
            pending = 0;
         end
         begin
            repeat (100) @(negedge ref_clk_in);
            chk1(1'(pending), 1'b1);
            drain = 1'b1;
         end
      join
      for (int k = 0; k < 400 && exp_q.size() > 0; k++) @(negedge ref_clk_in);
      chk8(8'(exp_q.size()), 8'h00);
      @(negedge ref_clk_in);
      flash_rd_data_in = 8'($urandom);
      flash_rd_valid_in = 1'b1;
      m_dat = flash_rd_data_in;
      @(negedge ref_clk_in);
      flash_rd_valid_in = 1'b0;
      rd(8'hB4);
      @(negedge ref_clk_in);
      rst_in = 1'b1;
      m_clr();
      repeat (4) @(negedge ref_clk_in);
      rst_in = 1'b0;
      @(negedge ref_clk_in);
      chk1(prog, 1'b0);
      h.send(8'h00, 2);
      rd(8'hB4);
      rd(8'h02);
      chk8(8'(h.tmo), 8'h00);
      end_sim();
   end
endmodule // tdf_top_tb_top
